// [src/supply_switch_map.svh]
// register offsets, field positions, reset values and timing for the switch
`ifndef SUPPLY_SWITCH_MAP_SVH
`define SUPPLY_SWITCH_MAP_SVH
`define SW_CONTROL_OFS 16'h1c00
`define SW_SUPPLY_STATUS_OFS 16'h1c01
`define SW_EVENT_STATUS_OFS 16'h1c02
`define SW_EVENT_ENABLE_OFS 16'h1c03
`define SW_FET_STATE_OFS 16'h1c04
`define CTL_FORCE_BUS_BIT 0
`define CTL_SWITCH_EN_N_BIT 1
`define CTL_RESET 8'h00
`define EVT_RESET 6'h00
`define EN_RESET 6'h00
`define EVT_TO_BUS_BIT 5
`define EVT_TO_MAIN_BIT 4
`define EVT_MAIN_LOST_BIT 3
`define EVT_MAIN_READY_BIT 2
`define EVT_BUS_LOST_BIT 1
`define EVT_BUS_READY_BIT 0
`define STEP_TIME_NS 50000
`define CLK_PERIOD_NS 100
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [src/supply_switch_pkg.sv]
// types shared by the dual supply switch sequencer
package supply_switch_pkg;
  typedef enum logic [3:0] {
    ST_DIODE   = 4'h0,
    ST_MAIN_1  = 4'h1,
    ST_MAIN    = 4'h2,
    ST_BUS     = 4'h3,
    ST_UP_B    = 4'h4,
    ST_UP_D    = 4'h5,
    ST_UP_A    = 4'h6,
    ST_DN_BD   = 4'h7,
    ST_DN_B    = 4'h8,
    ST_DN_C    = 4'h9
  } seq_state_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } fet_gates_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// [src/dual_supply_switch_sequencer.sv]
// sequencer, status and register bank for the dual supply switch
// Operation
// - both supplies not good: A and C open, B and D closed
// - main only good: open D, short A 50us later
// - bus only good: run from bus path, never back-drive main rail
// - on bus, main good detected: open C at once
// - short B 50us after C opened
// - open D 50us after B shorted
// - short A 50us after D opened; main feeds regulator
// - on main, bus becoming good changes no FET
// - both present, bus lost: path kept, bus lost event raised
// - both present, main lost: open A first
// - 50us after A opened close bypass D: power-on configuration
// - 50us later open B: bus feeds through diode
// - 50us after B opened short C: bus feeds directly
// - both good and no override: select main supply
// - override bit 0 forces bus supply, only from main with bus present
// - interrupt stays asserted until all enabled status bits cleared
// - per-event enables; enabled events drive wake output
// - control bit 1 active-low switch enable, reset 0
// - status bit 5 reflects main supply power-on-reset
// - status bit 4 reflects bus supply power-on-reset
// - status bit 2 rails ready, reset value 1; code reads the rails_ready input directly, with no reset value
// - status bits 1,0 report main and bus gate-off
// - six sticky events, write 1 clears, write 0 ignored
// - enable bit 0 blocks its event from interrupt; reset 0
`include "supply_switch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_supply_switch_sequencer #(
  parameter int STEP_CNT = `STEP_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire supply_switch_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic main_supply_good,
  input wire logic bus_supply_good,
  input wire logic main_supply_por,
  input wire logic bus_supply_por,
  input wire logic rails_ready,
  input wire logic main_gate_off,
  input wire logic bus_gate_off,
  output supply_switch_pkg::fet_gates_t fet_closed,
  output logic switch_enable_n,
  output logic switch_irq,
  output logic switch_wake
);
  localparam int CW = $clog2(STEP_CNT + 1);

  // ************************************************************
  // sequencer
  // ************************************************************
  supply_switch_pkg::seq_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic force_bus_r, force_bus_nxt;
  logic en_n_r, en_n_nxt;
  logic to_bus_ev, to_main_ev;
  logic expired;

  assign expired = (cnt_r == CW'(STEP_CNT - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    to_bus_ev = 1'b0;
    to_main_ev = 1'b0;
    case (state_r)
      supply_switch_pkg::ST_DIODE: begin
        cnt_nxt = '0;
        if (main_supply_good && !bus_supply_good) begin
          state_nxt = supply_switch_pkg::ST_MAIN_1;
        end else if (bus_supply_good && !main_supply_good) begin
          state_nxt = supply_switch_pkg::ST_DN_B;
        end else if (bus_supply_good && main_supply_good) begin
          state_nxt = supply_switch_pkg::ST_MAIN_1;
        end
      end
      supply_switch_pkg::ST_MAIN_1: begin
        cnt_nxt = cnt_r + CW'(1);
        if (!main_supply_good) begin
          state_nxt = supply_switch_pkg::ST_DIODE;
        end else if (expired) begin
          state_nxt = supply_switch_pkg::ST_MAIN;
          cnt_nxt = '0;
        end
      end
      supply_switch_pkg::ST_MAIN: begin
        cnt_nxt = '0;
        // bus arriving leaves the gates alone; only main loss or override leaves main
        if (!main_supply_good) begin
          state_nxt = supply_switch_pkg::ST_DN_BD;
          to_bus_ev = bus_supply_good;
        end else if (force_bus_r && bus_supply_good) begin
          state_nxt = supply_switch_pkg::ST_DN_BD;
          to_bus_ev = 1'b1;
        end
      end
      supply_switch_pkg::ST_BUS: begin
        cnt_nxt = '0;
        if (!bus_supply_good) begin
          state_nxt = supply_switch_pkg::ST_DIODE;
        end else if (main_supply_good && !force_bus_r) begin
          state_nxt = supply_switch_pkg::ST_UP_B;
        end
      end
      supply_switch_pkg::ST_UP_B,
      supply_switch_pkg::ST_UP_D,
      supply_switch_pkg::ST_UP_A: begin
        cnt_nxt = cnt_r + CW'(1);
        if (!main_supply_good) begin
          state_nxt = supply_switch_pkg::ST_DIODE;
          cnt_nxt = '0;
        end else if (expired) begin
          cnt_nxt = '0;
          case (state_r)
            supply_switch_pkg::ST_UP_B:
              state_nxt = supply_switch_pkg::ST_UP_D;
            supply_switch_pkg::ST_UP_D:
              state_nxt = supply_switch_pkg::ST_UP_A;
            default: begin
              state_nxt = supply_switch_pkg::ST_MAIN;
              to_main_ev = 1'b1;
            end
          endcase
        end
      end
      supply_switch_pkg::ST_DN_BD,
      supply_switch_pkg::ST_DN_B,
      supply_switch_pkg::ST_DN_C: begin
        cnt_nxt = cnt_r + CW'(1);
        if (!bus_supply_good) begin
          state_nxt = supply_switch_pkg::ST_DIODE;
          cnt_nxt = '0;
        end else if (expired) begin
          cnt_nxt = '0;
          case (state_r)
            supply_switch_pkg::ST_DN_BD:
              state_nxt = supply_switch_pkg::ST_DN_B;
            supply_switch_pkg::ST_DN_B:
              state_nxt = supply_switch_pkg::ST_DN_C;
            default:
              state_nxt = supply_switch_pkg::ST_BUS;
          endcase
        end
      end
      default: begin
        state_nxt = supply_switch_pkg::ST_DIODE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= supply_switch_pkg::ST_DIODE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // gate pattern per state; a,b,c,d = 1 means closed
  always_comb begin
    case (state_r)
      supply_switch_pkg::ST_DIODE: fet_closed = 4'b0101;
      supply_switch_pkg::ST_MAIN_1: fet_closed = 4'b0100;
      supply_switch_pkg::ST_MAIN: fet_closed = 4'b1100;
      supply_switch_pkg::ST_BUS: fet_closed = 4'b0011;
      supply_switch_pkg::ST_UP_B: fet_closed = 4'b0001;
      supply_switch_pkg::ST_UP_D: fet_closed = 4'b0101;
      supply_switch_pkg::ST_UP_A: fet_closed = 4'b0100;
      supply_switch_pkg::ST_DN_BD: fet_closed = 4'b0100;
      supply_switch_pkg::ST_DN_B: fet_closed = 4'b0101;
      supply_switch_pkg::ST_DN_C: fet_closed = 4'b0001;
      default: fet_closed = 4'b0101;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [5:0] evt_r, evt_nxt, en_r, en_nxt, raw_ev;
  logic [7:0] rdata_nxt;
  logic main_por_r, bus_por_r;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  // each POR edge is one event; bus loss is reported on every path
  always_comb begin
    raw_ev = '0;
    raw_ev[`EVT_TO_BUS_BIT] = to_bus_ev;
    raw_ev[`EVT_TO_MAIN_BIT] = to_main_ev;
    raw_ev[`EVT_MAIN_LOST_BIT] = main_por_r && !main_supply_por;
    raw_ev[`EVT_MAIN_READY_BIT] = !main_por_r && main_supply_por;
    raw_ev[`EVT_BUS_LOST_BIT] = bus_por_r && !bus_supply_por;
    raw_ev[`EVT_BUS_READY_BIT] = !bus_por_r && bus_supply_por;
  end

  always_comb begin
    force_bus_nxt = force_bus_r;
    en_n_nxt = en_n_r;
    en_nxt = en_r;
    evt_nxt = evt_r;
    if (req.wr && hit(req.addr, `SW_CONTROL_OFS)) begin
      force_bus_nxt = req.wdata[`CTL_FORCE_BUS_BIT];
      en_n_nxt = req.wdata[`CTL_SWITCH_EN_N_BIT];
    end
    if (req.wr && hit(req.addr, `SW_EVENT_ENABLE_OFS)) begin
      en_nxt = req.wdata[5:0];
    end
    if (req.wr && hit(req.addr, `SW_EVENT_STATUS_OFS)) begin
      evt_nxt = evt_r & ~req.wdata[5:0];
    end
    evt_nxt = evt_nxt | raw_ev; // set beats clear
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `SW_CONTROL_OFS: rdata_nxt = {6'h00, en_n_r, force_bus_r};
        `SW_SUPPLY_STATUS_OFS: rdata_nxt = {2'h0, main_supply_por,
          bus_supply_por, 1'b0, rails_ready, main_gate_off,
          bus_gate_off};
        `SW_EVENT_STATUS_OFS: rdata_nxt = {2'h0, evt_r};
        `SW_EVENT_ENABLE_OFS: rdata_nxt = {2'h0, en_r};
        `SW_FET_STATE_OFS: rdata_nxt = {6'h00,
          fet_closed.c, fet_closed.a};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      force_bus_r <= 1'(`CTL_RESET >> `CTL_FORCE_BUS_BIT);
      en_n_r <= 1'(`CTL_RESET >> `CTL_SWITCH_EN_N_BIT);
      en_r <= `EN_RESET;
      evt_r <= `EVT_RESET;
      rdata <= 8'h00;
      main_por_r <= 1'b0;
      bus_por_r <= 1'b0;
    end else begin
      force_bus_r <= force_bus_nxt;
      en_n_r <= en_n_nxt;
      en_r <= en_nxt;
      evt_r <= evt_nxt;
      rdata <= rdata_nxt;
      main_por_r <= main_supply_por;
      bus_por_r <= bus_supply_por;
    end
  end

  assign switch_enable_n = en_n_r;
  // level output, held until every enabled pending bit is cleared
  assign switch_irq = |(evt_r & en_r);
  assign switch_wake = |(evt_r & en_r);

  // ************************************************************
  // assertions
  // ************************************************************
  idle_gates_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!main_supply_good && !bus_supply_good &&
     state_r == supply_switch_pkg::ST_DIODE) |-> fet_closed == 4'b0101)
    else $error("diode gate pattern wrong");
  main_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == supply_switch_pkg::ST_DIODE && main_supply_good &&
     !bus_supply_good) |=> !fet_closed.d && !fet_closed.a)
    else $error("d not opened first");
  step_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    ($changed(state_r) && state_r == supply_switch_pkg::ST_UP_D)
    |-> $past(cnt_r) == CW'(STEP_CNT - 1))
    else $error("step advanced early");
  c_open_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == supply_switch_pkg::ST_BUS && main_supply_good &&
     !force_bus_r) |=> !fet_closed.c)
    else $error("c not opened on main good");
  bus_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == supply_switch_pkg::ST_MAIN && main_supply_good &&
     !force_bus_r) |=> fet_closed == 4'b1100)
    else $error("main path disturbed");
  a_open_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == supply_switch_pkg::ST_MAIN && !main_supply_good)
    |=> !fet_closed.a)
    else $error("a not opened on main loss");
  w1c_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    (req.wr && req.addr == `SW_EVENT_STATUS_OFS && req.wdata[0] &&
     !raw_ev[0]) |=> !evt_r[0])
    else $error("event not cleared");
  irq_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    (en_r == 6'h00) |-> !switch_irq)
    else $error("masked interrupt seen");
  read_ctl_a: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && req.addr == `SW_CONTROL_OFS) |=>
    rdata == {6'h00, $past(en_n_r), $past(force_bus_r)})
    else $error("control read wrong");
  up_cov: cover property (@(posedge clk) disable iff (!arst_n)
    state_r == supply_switch_pkg::ST_UP_A ##1
    state_r == supply_switch_pkg::ST_MAIN);
  dn_cov: cover property (@(posedge clk) disable iff (!arst_n)
    state_r == supply_switch_pkg::ST_DN_C ##1
    state_r == supply_switch_pkg::ST_BUS);
  irq_cov: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(switch_irq));
endmodule // dual_supply_switch_sequencer
`default_nettype wire

// [verification/dual_supply_switch_sequencer_tb.sv]
// self-checking bench for the dual supply switch sequencer
`include "supply_switch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_supply_switch_sequencer_tb;
  // short step keeps the run brief; the 50us step checks scale from it, immediate steps use a fixed 4-cycle limit
  localparam int S = 4;
  logic clk, arst_n, mg, bg, mp, bp, rr, mgo, bgo, sw_en_n, irq, wake;
  supply_switch_pkg::reg_req_t req;
  supply_switch_pkg::fet_gates_t fet;
  logic [7:0] rdata;
  int n_mismatch, n_compared, evt_m, en_m;
  int unsigned seed = 22;

  dual_supply_switch_sequencer #(.STEP_CNT(S)) i_dual_supply_switch_sequencer (
    .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .main_supply_good(mg), .bus_supply_good(bg), .main_supply_por(mp),
    .bus_supply_por(bp), .rails_ready(rr), .main_gate_off(mgo),
    .bus_gate_off(bgo), .fet_closed(fet), .switch_enable_n(sw_en_n),
    .switch_irq(irq), .switch_wake(wake));

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // ***************************************
  // checking and bus tasks
  // ***************************************
  task summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= {a, v, 2'b10};
    @(posedge clk);
    req <= '0;
    if (a == `SW_EVENT_STATUS_OFS) evt_m &= ~int'(v[5:0]);
    if (a == `SW_EVENT_ENABLE_OFS) en_m = v[5:0];
  endtask

  task rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= {a, 8'h00, 2'b01};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, e);
  endtask

  task evchk;
    rchk(`SW_EVENT_STATUS_OFS, 8'(evt_m));
    chk({7'h0, irq}, 8'(|(evt_m & en_m)));
    chk({7'h0, wake}, 8'(|(evt_m & en_m)));
  endtask

  task stchk;
    logic [31:0] r;
    r = xs();
    @(posedge clk);
    {rr, mgo, bgo} <= r[2:0];
    #1 rchk(`SW_SUPPLY_STATUS_OFS, {2'b0, mp, bp, 1'b0, rr, mgo, bgo});
  endtask

  // por edges are what the event latches watch
  task sup(input logic m, input logic b);
    @(posedge clk);
    if (m && !mp) evt_m |= 4;
    if (!m && mp) evt_m |= 8;
    if (b && !bp) evt_m |= 1;
    if (!b && bp) evt_m |= 2;
    mg <= m;
    mp <= m;
    bg <= b;
    bp <= b;
  endtask

  task step(input logic [3:0] e, input int lo, input int hi);
    logic [3:0] s;
    int n;
    s = fet;
    n = 0;
    while (fet === s && n < hi) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= hi) begin
      n_mismatch++;
      $display("[FAIL] %0t switch step missing", $time);
      summarize();
    end
    chk({4'h0, fet}, {4'h0, e});
    chk({7'h0, n >= lo}, 8'h01);
  endtask

  task hold(input int n);
    logic [3:0] s;
    s = fet;
    repeat (n) begin
      @(posedge clk);
      #1 chk({4'h0, fet}, {4'h0, s});
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] %0t run timed out", $time);
    summarize();
  end

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    {arst_n, mg, bg, mp, bp, rr, mgo, bgo} = '0;
    req = '0;
    {n_mismatch, n_compared, evt_m, en_m} = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1;
    #1 chk({4'h0, fet}, 8'h05);
    chk({7'h0, sw_en_n}, 8'h00);
    rchk(`SW_CONTROL_OFS, 8'h00);
    evchk();
    rchk(`SW_EVENT_ENABLE_OFS, 8'h00);
    rchk(`SW_FET_STATE_OFS, 8'h00);
    rchk(16'h1c05, 8'h00);
    stchk();
    wr(`SW_EVENT_ENABLE_OFS, 8'hff);
    rchk(`SW_EVENT_ENABLE_OFS, 8'h3f);
    sup(0, 1);
    step(4'h1, S, 2 * S + 4);
    step(4'h3, S, S + 3);
    rchk(`SW_FET_STATE_OFS, 8'h02);
    evchk();
    $display("test bus_only done");
    sup(1, 1);
    step(4'h1, 0, 4);
    step(4'h5, S, S + 3);
    step(4'h4, S, S + 3);
    step(4'hc, S, S + 3);
    evt_m |= 16;
    rchk(`SW_FET_STATE_OFS, 8'h01);
    evchk();
    stchk();
    $display("test handover done");
    sup(1, 0);
    hold(3 * S);
    evchk();
    sup(1, 1);
    hold(3 * S);
    wr(`SW_EVENT_STATUS_OFS, 8'h00);
    evchk();
    wr(`SW_EVENT_STATUS_OFS, 8'h10);
    evchk();
    wr(`SW_EVENT_STATUS_OFS, 8'hff);
    evchk();
    $display("test events done");
    sup(0, 1);
    step(4'h4, 0, 4);
    evt_m |= 32;
    step(4'h5, S, S + 3);
    step(4'h1, S, S + 3);
    step(4'h3, S, S + 3);
    evchk();
    $display("test main_lost done");
    @(posedge clk);
    {arst_n, mg, bg, mp, bp} <= '0;
    repeat (3) @(posedge clk);
    arst_n <= 1;
    {evt_m, en_m} = '0;
    #1 chk({4'h0, fet}, 8'h05);
    sup(1, 0);
    step(4'h4, 0, 4);
    step(4'hc, S, S + 3);
    sup(1, 1);
    hold(3 * S);
    $display("test main_only done");
    wr(`SW_EVENT_ENABLE_OFS, 8'h3f);
    wr(`SW_CONTROL_OFS, 8'h01);
    step(4'h4, 0, 4);
    evt_m |= 32;
    step(4'h5, S, S + 3);
    step(4'h1, S, S + 3);
    step(4'h3, S, S + 3);
    hold(2 * S);
    rchk(`SW_CONTROL_OFS, 8'h01);
    evchk();
    wr(`SW_CONTROL_OFS, 8'h00);
    step(4'h1, 0, 4);
    step(4'h5, S, S + 3);
    step(4'h4, S, S + 3);
    step(4'hc, S, S + 3);
    evt_m |= 16;
    evchk();
    $display("test override done");
    wr(`SW_EVENT_STATUS_OFS, 8'hff);
    wr(`SW_EVENT_ENABLE_OFS, 8'h04);
    sup(1, 0);
    hold(3);
    evchk();
    wr(`SW_EVENT_ENABLE_OFS, 8'h02);
    evchk();
    wr(`SW_CONTROL_OFS, 8'hfe);
    rchk(`SW_CONTROL_OFS, 8'h02);
    chk({7'h0, sw_en_n}, 8'h01);
    $display("test mask_control done");
    summarize();
  end
endmodule // dual_supply_switch_sequencer_tb
`default_nettype wire
